/* File: src/eoc_pkg.sv */
/*
 * Constants, field layouts and carrier types for the output stage and
 * recording clock control of the channel modulator.
 * Assumes an 8-bit register port and a 25 MHz system clock.
 */
`default_nettype none
package eoc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h34; // recording_clock_pll_config
    localparam logic [7:0] OFS_MOD_CONFIG   = 8'h3d; // modulator_output_config
    localparam logic [7:0] OFS_MOD_CONFIG2  = 8'h3e; // modulator_output_config_two
    localparam logic [7:0] OFS_CTRL_STATUS  = 8'h3f; // reference select and block state
    localparam logic [7:0] REG_RESET        = 8'h00;
    // Field positions in modulator_output_config
    localparam int BIT_CLK_SEL    = 7;
    localparam int BIT_LENGTHEN   = 6;
    localparam int BIT_LASER_EN   = 5;
    localparam int BIT_LASER_FRC  = 4;
    localparam int BIT_GATE_FRC   = 3;
    localparam int BIT_FMT_HI     = 2;
    localparam int BIT_FMT_LO     = 1;
    localparam int BIT_PANIC_EN   = 0;
    // Field positions in modulator_output_config_two
    localparam int BIT_OVR_MODE   = 2;
    localparam int BIT_OVR_ON     = 1;
    localparam int BIT_FMT_TOP    = 0;
    // Field positions in recording_clock_pll_config
    localparam int BIT_BW_HI      = 7;
    localparam int BIT_BW_LO      = 5;
    localparam int BIT_BYPASS     = 4;
    localparam int BIT_DIV_HI     = 3;
    localparam int BIT_DIV_LO     = 1;
    // Output format codes
    localparam logic [2:0] FMT_ZERO   = 3'h0;
    localparam logic [2:0] FMT_NORMAL = 3'h1;
    localparam logic [2:0] FMT_I3     = 3'h2;
    localparam logic [2:0] FMT_I11    = 3'h3;
    localparam logic [2:0] FMT_CALIB  = 3'h5;
    localparam logic [3:0] RUN_I3     = 4'h3;
    localparam logic [3:0] RUN_I11    = 4'hb;
    localparam logic [3:0] CALIB_LAST = 4'h9; // Ten runs: 3-3-4-4-5-5-6-6-7-7
    // Reference sources
    localparam logic [1:0] REF_WOBBLE = 2'h0;
    localparam logic [1:0] REF_WORD   = 2'h1;
    localparam logic [1:0] REF_SYSDIV = 2'h2;
    localparam logic [7:0] SYSDIV_REF = 8'hbf; // System clock / 192, count 0..191
    // Digital loop defaults
    localparam logic [15:0] NCO_STEP_INIT = 16'h1000;
    localparam logic [7:0]  DPLL_MULT     = 8'h10; // NCO ticks expected per reference
    // Run-length carrier for normal data
    typedef struct packed {
        logic       valid;
        logic [3:0] length; // Channel bits in the run
    } eoc_run_type;
    typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} eoc_state_type;
endpackage : eoc_pkg
`default_nettype wire

/* File: src/eoc_output_clock.sv */
/*
 * Output stage and recording clock control: register port, reference
 * mux and digital loop, bypass mux, divider, clock gating, run-length
 * serialiser and laser enable.
 * Assumes write flags, position error and run input come from logic on
 * clk; panic, wobble, word clock and analog loop clock are pins.
 * The analog loop sits outside; its output returns as a pin sampled on
 * clk, so it must run well below half the system clock rate.
 */
// The address-and-strobe port is this design's own decision.
`default_nettype none
module eoc_output_clock
    import eoc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        laser_write_flag,
    input  wire logic        data_flow_flag,
    input  wire logic        panic_pin,
    input  wire logic        wobble_ref_pin,
    input  wire logic        word_clock_pin,
    input  wire logic        analog_loop_clock_pin,
    input  wire logic [6:0]  position_error,
    input  wire eoc_run_type run_in,
    output var  logic        run_ready,
    output var  logic        dpll_clock_out,
    output var  logic        recording_clock,
    output var  logic        recording_clock_doubled,
    output var  logic        efm_data_out,
    output var  logic        laser_drive_output
);
    // Divisor table for the analog loop output
    function automatic logic [4:0] divisor_of(input logic [2:0] code);
        case (code)
            3'h0: divisor_of = 5'h01;
            3'h1: divisor_of = 5'h02;
            3'h2: divisor_of = 5'h03;
            3'h3: divisor_of = 5'h04;
            3'h4: divisor_of = 5'h06;
            3'h5: divisor_of = 5'h08;
            3'h6: divisor_of = 5'h0c;
            default: divisor_of = 5'h10;
        endcase
    endfunction : divisor_of

    // Each bandwidth step halves the loop gain: 400, 200, 100, 50, 25 Hz
    // Codes above the last defined one reuse the narrowest bandwidth
    function automatic logic [2:0] bw_shift(input logic [2:0] code);
        bw_shift = (code > 3'h4) ? 3'h4 : code;
    endfunction : bw_shift

    // Formats that run the serialiser; every other code holds the line low
    function automatic logic fmt_active(input logic [2:0] code);
        fmt_active = (code == FMT_NORMAL) || (code == FMT_I3) ||
                     (code == FMT_I11) || (code == FMT_CALIB);
    endfunction : fmt_active

    logic [7:0] clock_config, mod_config, mod_config2, ctrl;
    logic [7:0] next_clock_config, next_mod_config, next_mod_config2, next_ctrl;
    logic [7:0] next_reg_rdata;
    // Two-stage synchronisers for the pins
    logic [3:0] sync_a, sync_b, sync_c;
    logic [15:0] nco_acc, nco_step, next_nco_acc, next_nco_step;
    logic [7:0]  ref_div, next_ref_div, tick_count, next_tick_count;
    logic        next_dpll_clock_out;
    logic [4:0]  div_cnt, next_div_cnt;
    logic        norm_phase, dbl_phase, next_norm_phase, next_dbl_phase;
    logic        next_recording_clock, next_recording_clock_doubled;
    logic        next_laser, next_data;
    logic        next_run_ready;
    eoc_state_type state, next_state;
    logic [3:0]  run_left, next_run_left, calib_idx, next_calib_idx;

    // Decoded configuration and per-cycle strobes
    logic [2:0]  fmt;
    logic        clock_run, dbl_ok, ref_edge, src_tick, norm_tick, dbl_tick, bit_tick;
    logic [4:0]  divisor;
    logic [3:0]  run_len;
    logic [16:0] nco_sum;
    logic signed [15:0] loop_err, trim;

    // Format, divisor and reference decode
    assign fmt      = {mod_config2[BIT_FMT_TOP], mod_config[BIT_FMT_HI:BIT_FMT_LO]};
    assign divisor  = divisor_of(clock_config[BIT_DIV_HI:BIT_DIV_LO]);
    assign dbl_ok   = ~divisor[0];
    assign ref_edge = (ctrl[1:0] == REF_WOBBLE) ? (sync_b[1] & ~sync_c[1]) :
                      (ctrl[1:0] == REF_WORD)   ? (sync_b[2] & ~sync_c[2]) :
                      (ctrl[1:0] == REF_SYSDIV) ? (ref_div == SYSDIV_REF) : 1'b0;
    // System clock in bypass, else rising edges of the analog loop clock
    assign src_tick = clock_config[BIT_BYPASS] ? 1'b1 : (sync_b[3] & ~sync_c[3]);
    // Doubled phase also ticks at the half count, only for even divisors
    assign norm_tick = src_tick && (div_cnt == divisor - 5'h01);
    assign dbl_tick  = norm_tick || (src_tick && dbl_ok && (div_cnt == divisor[4:1] - 5'h01));
    // Override mode wins over gate force and the data flow flag
    assign clock_run = mod_config2[BIT_OVR_MODE] ? mod_config2[BIT_OVR_ON]
                     : (mod_config[BIT_GATE_FRC] | data_flow_flag);
    // One channel bit per rising edge of the selected clock
    assign bit_tick  = clock_run && ((mod_config[BIT_CLK_SEL] && dbl_ok) ?
                       (dbl_tick && !dbl_phase) : (norm_tick && !norm_phase));
    // Carry out of the accumulator is the digital loop output tick
    assign nco_sum   = {1'b0, nco_acc} + {1'b0, nco_step};

    // Calibration runs and fixed patterns
    always_comb begin
        case (fmt)
            FMT_I3:    run_len = RUN_I3;
            FMT_I11:   run_len = RUN_I11;
            FMT_CALIB: run_len = 4'h3 + {1'b0, calib_idx[3:1]};
            default:   run_len = run_in.length;
        endcase
    end

    // Digital loop error: reference count mismatch plus position error
    // The step is trimmed only at reference edges, so a lost reference
    // leaves the frequency where it was instead of letting it drift
    always_comb begin
        loop_err = 16'(signed'({8'h00, tick_count})) - 16'(signed'({8'h00, DPLL_MULT}));
        trim = ((loop_err <<< 6) + 16'(signed'(position_error)))
               >>> bw_shift(clock_config[BIT_BW_HI:BIT_BW_LO]);
    end

    // Registers, reference divider, digital loop and divider
    always_comb begin
        next_clock_config = clock_config;
        next_mod_config   = mod_config;
        next_mod_config2  = mod_config2;
        next_ctrl         = ctrl;
        next_reg_rdata    = 8'h00;
        if (reg_write) begin
            // Reserved bits steer nothing; they are stored as written, except in the control register where they are stored as zero
            case (reg_addr)
                OFS_CLOCK_CONFIG: next_clock_config = reg_wdata;
                OFS_MOD_CONFIG:   next_mod_config   = reg_wdata;
                OFS_MOD_CONFIG2:  next_mod_config2  = reg_wdata;
                OFS_CTRL_STATUS:  next_ctrl         = {6'h00, reg_wdata[1:0]};
                default:          next_ctrl         = ctrl;
            endcase
        end
        // Configuration registers are write-only and read as zero
        if (reg_read && reg_addr == OFS_CTRL_STATUS) begin
            next_reg_rdata = {ctrl[1:0], 1'b0, clock_run, dbl_ok, efm_data_out,
                              recording_clock, laser_drive_output};
        end
        next_ref_div = (ref_div == SYSDIV_REF) ? 8'h00 : ref_div + 8'h01;
        next_nco_acc = nco_sum[15:0];
        next_nco_step = nco_step;
        next_tick_count = tick_count + {7'h00, nco_sum[16]};
        next_dpll_clock_out = dpll_clock_out ^ nco_sum[16];
        // Too many ticks per reference slows the loop, and the reverse
        if (ref_edge) begin
            next_nco_step = nco_step - 16'(trim);
            next_tick_count = 8'h00;
        end
        next_div_cnt = div_cnt;
        if (src_tick) begin
            next_div_cnt = (div_cnt >= divisor - 5'h01) ? 5'h00 : div_cnt + 5'h01;
        end
        next_norm_phase = norm_phase ^ norm_tick;
        next_dbl_phase  = dbl_ok ? (dbl_phase ^ dbl_tick) : 1'b0;
        // Gated clocks park low so the laser driver sees no runt edges
        next_recording_clock = clock_run &&
            ((mod_config[BIT_CLK_SEL] && dbl_ok) ? next_dbl_phase : next_norm_phase);
        next_recording_clock_doubled = clock_run && dbl_ok && next_dbl_phase;
    end

    // Configuration, loop and clock state registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clock_config <= REG_RESET;
            mod_config <= REG_RESET;
            mod_config2 <= REG_RESET;
            ctrl <= REG_RESET;
            reg_rdata <= 8'h00;
            ref_div <= 8'h00;
            nco_acc <= 16'h0000;
            nco_step <= NCO_STEP_INIT;
            tick_count <= 8'h00;
            dpll_clock_out <= 1'b0;
            div_cnt <= 5'h00;
            norm_phase <= 1'b0;
            dbl_phase <= 1'b0;
            recording_clock <= 1'b0;
            recording_clock_doubled <= 1'b0;
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_c <= 4'h0;
        end else begin
            clock_config <= next_clock_config;
            mod_config <= next_mod_config;
            mod_config2 <= next_mod_config2;
            ctrl <= next_ctrl;
            reg_rdata <= next_reg_rdata;
            ref_div <= next_ref_div;
            nco_acc <= next_nco_acc;
            nco_step <= next_nco_step;
            tick_count <= next_tick_count;
            dpll_clock_out <= next_dpll_clock_out;
            div_cnt <= next_div_cnt;
            norm_phase <= next_norm_phase;
            dbl_phase <= next_dbl_phase;
            recording_clock <= next_recording_clock;
            recording_clock_doubled <= next_recording_clock_doubled;
            // Pins pass two stages before any logic looks at them
            sync_a <= {analog_loop_clock_pin, word_clock_pin, wobble_ref_pin, panic_pin};
            sync_b <= sync_a;
            sync_c <= sync_b; // Edge history, read only after the second stage
        end
    end

    // Serialiser and laser enable
    // The new level is known at load time, which is why lengthening can
    // look at the output itself to find the zero runs
    always_comb begin
        next_state = state;
        next_run_left = run_left;
        next_calib_idx = calib_idx;
        next_data = efm_data_out;
        next_run_ready = 1'b0;
        // Panic wins over force, force over write-flag gating
        next_laser = !(mod_config[BIT_PANIC_EN] && sync_b[0]) &&
                     (mod_config[BIT_LASER_FRC] ||
                      (mod_config[BIT_LASER_EN] && laser_write_flag));
        case (state)
            ST_HOLD: begin
                next_data = 1'b0;
                if (fmt_active(fmt)) begin
                    next_state = ST_LOAD;
                    next_calib_idx = 4'h0;
                end
            end
            ST_LOAD: begin
                // A missing normal-data run stretches the current level
                if (fmt != FMT_NORMAL || run_in.valid) begin
                    next_run_left = run_len + {3'h0, mod_config[BIT_LENGTHEN] & ~efm_data_out};
                    next_run_ready = (fmt == FMT_NORMAL);
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (bit_tick) begin
                    next_run_left = run_left - 4'h1;
                    if (run_left <= 4'h1) begin
                        next_data = ~efm_data_out;
                        next_calib_idx = (calib_idx == CALIB_LAST) ? 4'h0 : calib_idx + 4'h1;
                        next_state = ST_LOAD;
                    end
                end
            end
            default: next_state = ST_HOLD;
        endcase
        // Reserved codes and code zero hold the output low
        // Leaving a format for code zero or a reserved code restarts its pattern from the first run
        if (!fmt_active(fmt)) begin
            next_state = ST_HOLD;
            next_data = 1'b0;
            next_run_ready = 1'b0;
        end
    end

    // Serialiser and laser registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_HOLD;
            run_left <= 4'h0;
            calib_idx <= 4'h0;
            efm_data_out <= 1'b0;
            run_ready <= 1'b0;
            laser_drive_output <= 1'b0;
        end else begin
            state <= next_state;
            run_left <= next_run_left;
            calib_idx <= next_calib_idx;
            efm_data_out <= next_data;
            run_ready <= next_run_ready;
            laser_drive_output <= next_laser;
        end
    end
endmodule : eoc_output_clock
`default_nettype wire

/* File: dv/eoc_output_clock_sva.sv */
/* Checker for eoc_output_clock: laser gating, clock gating, run pulses.
   Assumes a bind to the top module; config is shadowed from writes. */
`default_nettype none
module eoc_output_clock_sva
    import eoc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       laser_write_flag,
    input wire logic       data_flow_flag,
    input wire logic       panic_pin,
    input wire logic       run_ready,
    input wire logic       recording_clock,
    input wire logic       recording_clock_doubled,
    input wire logic       laser_drive_output
);
    logic [7:0] mod_cfg, mod_cfg2, clk_cfg;
    // Shadow copies, since the registers cannot be read back
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mod_cfg <= REG_RESET;
            mod_cfg2 <= REG_RESET;
            clk_cfg <= REG_RESET;
        end else if (reg_write) begin
            if (reg_addr == OFS_MOD_CONFIG) mod_cfg <= reg_wdata;
            if (reg_addr == OFS_MOD_CONFIG2) mod_cfg2 <= reg_wdata;
            if (reg_addr == OFS_CLOCK_CONFIG) clk_cfg <= reg_wdata;
        end
    end
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Panic needs two sync stages and the output flop before it bites
    sequence panic_held;
        (mod_cfg[0] && panic_pin) [*4];
    endsequence
    AST_LASER_IDLE: assert property (
        (mod_cfg[5:4] == 2'h0) [*3] |-> !laser_drive_output)
        else $error("laser on with gating off");
    AST_LASER_FORCE: assert property (
        (mod_cfg[4] && !mod_cfg[0]) [*3] |-> laser_drive_output)
        else $error("laser off while forced");
    AST_LASER_WRITE: assert property (
        (mod_cfg[5] && !mod_cfg[0] && laser_write_flag) [*3] |-> laser_drive_output)
        else $error("laser off during write");
    AST_PANIC_OFF: assert property (
        panic_held |-> !laser_drive_output)
        else $error("laser on during panic");
    AST_ODD_NO_DOUBLE: assert property (
        (clk_cfg[3:1] == 3'h0 || clk_cfg[3:1] == 3'h2) [*4] |-> !recording_clock_doubled)
        else $error("doubled clock with odd divisor");
    AST_OVERRIDE_OFF: assert property (
        (mod_cfg2[2:1] == 2'h2) [*4] |-> !recording_clock)
        else $error("clock runs in override off");
    AST_NO_FLOW_OFF: assert property (
        (!mod_cfg2[2] && !mod_cfg[3] && !data_flow_flag) [*4] |-> !recording_clock)
        else $error("clock runs without data flow");
    AST_RUN_PULSE: assert property (
        run_ready |=> !run_ready)
        else $error("run taken twice in a row");
endmodule : eoc_output_clock_sva
bind eoc_output_clock eoc_output_clock_sva u_sva (.clk, .rstn, .reg_addr, .reg_wdata,
    .reg_write, .laser_write_flag, .data_flow_flag, .panic_pin, .run_ready,
    .recording_clock, .recording_clock_doubled, .laser_drive_output);
`default_nettype wire

/* File: dv/eoc_laser_model.sv */
/* Laser driver side: raises the panic line on request.
   Assumes requests come on the system clock. */
`default_nettype none
module eoc_laser_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic panic_req,
    output var  logic panic_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Line is always driven, so it never floats between requests
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) panic_pin <= 1'b0;
        else panic_pin <= panic_req;
    end
endmodule : eoc_laser_model
`default_nettype wire

/* File: dv/eoc_output_clock_tb_top.sv */
/* Bench for eoc_output_clock: gating table, divisors, bypass, patterns.
   Assumes the bound checker and the laser model beside the design. */
`default_nettype none
module eoc_output_clock_tb_top
    import eoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] mc;
        logic [7:0] m2;
        logic [4:0] io; // Write flag, flow flag, panic, laser, clock runs
    } eoc_row_type;
    logic        clk, rstn, reg_write, reg_read, wflag, dflow, panic_req, aclk;
    logic        run_ready, dpll_out, rclk, rclk2, efm_out, laser, panic_pin;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [15:0] n, k;
    eoc_run_type run_in;
    int          err_total, total_checks, i;
    int          divs [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    int          calib [10] = '{3, 4, 4, 5, 5, 6, 6, 7, 7, 3};
    eoc_row_type rows [9] = '{'{8'h00, 8'h00, 5'h19}, '{8'h20, 8'h00, 5'h12},
        '{8'h20, 8'h00, 5'h09}, '{8'h10, 8'h00, 5'h02}, '{8'h11, 8'h00, 5'h04},
        '{8'h10, 8'h00, 5'h06}, '{8'h08, 8'h00, 5'h01}, '{8'h08, 8'h04, 5'h08},
        '{8'h00, 8'h06, 5'h01}};
    eoc_output_clock DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .laser_write_flag(wflag), .data_flow_flag(dflow), .panic_pin,
        .wobble_ref_pin(1'b0), .word_clock_pin(1'b0), .analog_loop_clock_pin(aclk),
        .position_error(7'h00), .run_in, .run_ready, .dpll_clock_out(dpll_out),
        .recording_clock(rclk), .recording_clock_doubled(rclk2),
        .efm_data_out(efm_out), .laser_drive_output(laser));
    eoc_laser_model u_laser (.clk, .rstn, .panic_req, .panic_pin);
    // System clock, and an analog loop clock of three system periods
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        aclk = 1'b0;
        #7;
        forever #60 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // Strobe is dropped a full cycle before any next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk("read data", 16'(exp), 16'(reg_rdata));
        @(posedge clk);
    endtask : rd
    // Settle, then cycles between two rising edges; 0 if none
    task automatic period(input logic dbl, output logic [15:0] len);
        logic prev, now;
        int c, first;
        first = -1;
        prev = 1'b1;
        len = 16'h0;
        repeat (40) @(posedge clk);
        for (c = 0; c < 100 && len == 0; c++) begin
            @(posedge clk);
            #1;
            now = dbl ? rclk2 : rclk;
            if (now === 1'b1 && prev === 1'b0) begin
                if (first >= 0) len = 16'(c - first);
                first = c;
            end
            prev = now;
        end
    endtask : period
    // Cycles until the serial level next changes
    task automatic gap(output logic [15:0] len);
        logic was;
        was = efm_out;
        len = 16'h0;
        do begin
            @(posedge clk);
            #1;
            len++;
        end while (efm_out === was && len < 16'd200);
        if (len >= 16'd200) begin
            err_total++;
            $display("wrong value serial toggle expected 1 seen 0");
            close_out();
        end
    endtask : gap
    task automatic sel(input logic [7:0] mc, input logic [7:0] m2);
        wr(OFS_MOD_CONFIG2, m2);
        wr(OFS_MOD_CONFIG, mc);
        gap(k);
    endtask : sel
    initial begin
        {reg_write, reg_read, wflag, dflow, panic_req, rstn} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        run_in = '{1'b1, 4'h4};
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset outputs", 16'h0, 16'({laser, efm_out, rclk}));
        rd(OFS_MOD_CONFIG, 8'h00);
        rd(8'h55, 8'h00);
        wr(OFS_CTRL_STATUS, 8'h02);
        rd(OFS_CTRL_STATUS, 8'h80);
        // Loop output must keep toggling at its reset step; the window ends before the first divided reference edge
        n = 16'h0;
        k = 16'(dpll_out);
        for (i = 0; i < 64; i++) begin
            @(posedge clk);
            #1;
            if (dpll_out !== k[0]) n++;
            k = 16'(dpll_out);
        end
        chk("loop clock toggles", 16'h1, 16'(n > 16'h2));
        wr(OFS_CLOCK_CONFIG, 8'h12);
        for (i = 0; i < 9; i++) begin
            {wflag, dflow, panic_req} <= rows[i].io[4:2];
            wr(OFS_MOD_CONFIG, rows[i].mc);
            wr(OFS_MOD_CONFIG2, rows[i].m2);
            period(1'b0, n);
            chk("laser", 16'(rows[i].io[1]), 16'(laser));
            chk("clock runs", 16'(rows[i].io[0]), 16'(n != 0));
            $display("gating row %0d done", i);
        end
        wr(OFS_MOD_CONFIG2, 8'h00);
        wr(OFS_MOD_CONFIG, 8'h08);
        for (i = 0; i < 8; i++) begin
            wr(OFS_CLOCK_CONFIG, 8'h10 | 8'(i << 1));
            period(1'b0, n);
            chk("period", 16'(2 * divs[i]), n);
            period(1'b1, n);
            chk("doubled period", (divs[i] % 2) ? 16'h0 : 16'(divs[i]), n);
        end
        wr(OFS_MOD_CONFIG, 8'h88);
        period(1'b0, n);
        chk("selected doubled", 16'h10, n);
        wr(OFS_MOD_CONFIG, 8'h08);
        wr(OFS_CLOCK_CONFIG, 8'h00);
        period(1'b0, n);
        chk("analog period", 16'h6, n);
        $display("clock tests done");
        wr(OFS_CLOCK_CONFIG, 8'h10);
        sel(8'h0c, 8'h00);
        gap(n);
        chk("I3 run", 16'h6, n);
        sel(8'h0e, 8'h00);
        gap(n);
        chk("I11 run", 16'h16, n);
        sel(8'h4c, 8'h00);
        gap(n);
        gap(k);
        chk("lengthened pair", 16'he, n + k);
        sel(8'h0a, 8'h00);
        gap(n);
        chk("normal run", 16'h8, n);
        wr(OFS_MOD_CONFIG, 8'h08);
        repeat (4) @(posedge clk);
        chk("hold level", 16'h0, 16'(efm_out));
        sel(8'h0a, 8'h01);
        for (i = 0; i < 10; i++) begin
            gap(n);
            chk("calibration run", 16'(2 * calib[i]), n);
        end
        $display("pattern tests done");
        close_out();
    end
endmodule : eoc_output_clock_tb_top
`default_nettype wire
